/* verilog/ldr_defs.vh */
`ifndef LDR_DEFS_VH
`define LDR_DEFS_VH
// bus address, seven bits
`define LDR_BUS_ADDR        7'h31
// register offsets
`define LDR_REG_CURRENT     8'h02
`define LDR_REG_PROTECT     8'h03
`define LDR_REG_DIM         8'h04
`define LDR_REG_STATUS      8'h06
// reset values
`define LDR_CURRENT_RST     8'h00
`define LDR_DIM_RST         8'h00
`define LDR_PROT_EN_RST     1'b1
`define LDR_GUARD_DIS_RST   1'b0
`define LDR_GUARD_LATCH_RST 1'b0
// synchroniser idle: bus lines high, status pins low, so no false edge after reset
`define LDR_SYNC_IDLE       10'h300
// protection register fields
`define LDR_PROT_EN_BIT     7
`define LDR_PROT_CLR_BIT    3
`define LDR_GUARD_DIS_BIT   2
`define LDR_GUARD_LATCH_BIT 1
`define LDR_FLAG_BIT        0
// identification field, value arbitrary
`define LDR_MAKER_ID        3'h5
// current code mapping
`define LDR_CODE_ZERO       8'h00
`define LDR_CODE_MIN        8'h20
// dimming modes and mixed-mode threshold (25 percent)
`define LDR_MODE_PWM        2'h0
`define LDR_MODE_DC         2'h1
`define LDR_MODE_MIXED      2'h2
`define LDR_MIX_THRESH      8'h40
`define LDR_DIM_FULL        8'hFF
// timing in 40 MHz system clocks, sized to the counters that use them
// 500 us of switch-node blanking
`define LDR_NODE_BLANK_CYC  16'h4E20
// 100 us between short-string rechecks
`define LDR_GUARD_RETRY_CYC 12'hFA0
// about 26 kHz chopping period, and its share per duty step
`define LDR_DIM_PERIOD_CYC  11'h602
`define LDR_DIM_STEP_CYC    3'h6
`endif

/* verilog/ldr_dim_pwm.v */
`timescale 1ns/1ps
`include "ldr_defs.vh"
module ldr_dim_pwm (
  input  wire       i_clk_sys,
  input  wire       i_rst,
  input  wire [7:0] i_duty,
  output reg        o_pwm
);
  localparam [10:0] PERIOD = `LDR_DIM_PERIOD_CYC;
  localparam [2:0]  STEP   = `LDR_DIM_STEP_CYC;
  reg  [10:0] cnt;
  wire [10:0] thresh = i_duty * STEP;

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt   <= 11'h000;
      o_pwm <= 1'b0;
    end else begin
      if (cnt == PERIOD - 11'h001)
        cnt <= 11'h000;
      else
        cnt <= cnt + 11'h001;
      // full code keeps the output high for the whole period
      o_pwm <= (i_duty == `LDR_DIM_FULL) || (cnt < thresh);
    end
  end
endmodule // ldr_dim_pwm

/* verilog/ldr_smbus_regs.v */
// Operation
// - code zero gives zero channel current
// - codes one to 0x20 give minimum current
// - above 0x20 current rises per code step
// - enabled fault drives fault output
// - protection bit 7 enables fault protection
// - detected fault sets read-only flag bit 0
// - writing one to bit 3 clears flag
// - switch node check armed after blanking
// - over-voltage sink pin turns channel off
// - bit 2 one disables string guard
// - bit 1 selects retry or latch
// - dimming register maps code to duty
// - register dimming only DC or mixed
// - status bit 7 flags zero current code
// - status bits 6:4 fixed maker code
// - write: address, command, data, all acknowledged
// - read: repeated start, data, host acks
// - mode bit selects pin or register dimming
`timescale 1ns/1ps
`include "ldr_defs.vh"
module ldr_smbus_regs #(
  parameter [15:0] P_NODE_BLANK_CYC = `LDR_NODE_BLANK_CYC
) (
  input  wire       i_clk_sys,
  input  wire       i_rst,
  input  wire       i_scl,
  input  wire       i_sda,
  output reg        o_sda_out,
  output reg        o_sda_oe,
  input  wire       i_enable,
  input  wire       i_switch_node_low,
  input  wire       i_switch_node_high,
  input  wire [3:0] i_channel_sink_pin_over,
  input  wire       i_dim_pin,
  input  wire       i_dim_src_reg,
  input  wire [1:0] i_dim_mode,
  output wire       o_fault,
  output wire [3:0] o_channel_on,
  output reg  [7:0] o_current_code,
  output reg  [7:0] o_dim_level,
  output reg        o_dim_pwm
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_CMD  = 7'h04;
  localparam [6:0] S_WR   = 7'h08;
  localparam [6:0] S_ACK  = 7'h10;
  localparam [6:0] S_RD   = 7'h20;
  localparam [6:0] S_RACK = 7'h40;
  localparam [11:0] RETRY = `LDR_GUARD_RETRY_CYC;

  // two-stage synchronisers; stage one is read only by stage two
  reg [9:0] sync1, sync2;
  reg       scl_d, sda_d;
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      sync1 <= `LDR_SYNC_IDLE;
      sync2 <= `LDR_SYNC_IDLE;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      sync1 <= {i_scl, i_sda, i_enable, i_switch_node_low, i_switch_node_high,
                i_channel_sink_pin_over, i_dim_pin};
      sync2 <= sync1;
      scl_d <= sync2[9];
      sda_d <= sync2[8];
    end
  end
  wire       scl_s   = sync2[9];
  wire       sda_s   = sync2[8];
  wire       en_s    = sync2[7];
  wire       node_lo_s = sync2[6];
  wire       node_hi_s = sync2[5];
  wire [3:0] over_s  = sync2[4:1];
  wire       pin_s   = sync2[0];

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

  // register storage
  reg [7:0] current_code, dim_duty;
  reg       prot_en, guard_dis, guard_latch, fault_flag;
  reg [6:0] state, after_ack;
  reg [3:0] bitcnt;
  reg [7:0] shreg, ptr, wr_addr, wr_data;
  reg       host_ack, wr_stb;
  reg [7:0] rd_word;
  always @* begin
    rd_word = 8'h00;
    case (ptr)
      `LDR_REG_CURRENT: rd_word = current_code;
      `LDR_REG_PROTECT: rd_word = {prot_en, 4'h0, guard_dis, guard_latch, fault_flag};
      `LDR_REG_DIM:     rd_word = dim_duty;
      `LDR_REG_STATUS:  rd_word = {(current_code == `LDR_CODE_ZERO), `LDR_MAKER_ID, 4'h0};
      default:          rd_word = 8'h00;
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      state     <= S_IDLE;
      after_ack <= S_IDLE;
      bitcnt    <= 4'h0;
      shreg     <= 8'h00;
      ptr       <= 8'h00;
      host_ack  <= 1'b0;
      o_sda_out <= 1'b0;
      o_sda_oe  <= 1'b0;
      wr_stb    <= 1'b0;
      wr_addr   <= 8'h00;
      wr_data   <= 8'h00;
    end else begin
      wr_stb    <= 1'b0;
      o_sda_out <= 1'b0;
      if (start_ev) begin
        // a repeated start lands here too
        state    <= S_ADDR;
        bitcnt   <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (stop_ev) begin
        state    <= S_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        if (scl_rise && (state == S_ADDR || state == S_CMD || state == S_WR)) begin
          shreg  <= {shreg[6:0], sda_s};
          bitcnt <= bitcnt + 4'h1;
        end
        case (state)
          S_IDLE: begin
            o_sda_oe <= 1'b0;
          end
          S_ADDR: begin
            if (scl_fall && bitcnt == 4'h8) begin
              if (shreg[7:1] == `LDR_BUS_ADDR) begin
                o_sda_oe  <= 1'b1;
                state     <= S_ACK;
                after_ack <= shreg[0] ? S_RD : S_CMD;
              end else begin
                state <= S_IDLE;
              end
            end
          end
          S_CMD: begin
            if (scl_fall && bitcnt == 4'h8) begin
              ptr       <= shreg;
              o_sda_oe  <= 1'b1;
              state     <= S_ACK;
              after_ack <= S_WR;
            end
          end
          S_WR: begin
            if (scl_fall && bitcnt == 4'h8) begin
              wr_stb    <= 1'b1;
              wr_addr   <= ptr;
              wr_data   <= shreg;
              ptr       <= ptr + 8'h01;
              o_sda_oe  <= 1'b1;
              state     <= S_ACK;
              after_ack <= S_WR;
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              bitcnt <= 4'h0;
              state  <= after_ack;
              if (after_ack == S_RD) begin
                shreg    <= {rd_word[6:0], 1'b0};
                o_sda_oe <= ~rd_word[7];
                bitcnt   <= 4'h1;
              end else begin
                o_sda_oe <= 1'b0;
              end
            end
          end
          S_RD: begin
            if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                o_sda_oe <= 1'b0;
                state    <= S_RACK;
                ptr      <= ptr + 8'h01;
              end else begin
                o_sda_oe <= ~shreg[7];
                shreg    <= {shreg[6:0], 1'b0};
                bitcnt   <= bitcnt + 4'h1;
              end
            end
          end
          S_RACK: begin
            if (scl_rise)
              host_ack <= ~sda_s;
            if (scl_fall) begin
              if (host_ack) begin
                shreg    <= {rd_word[6:0], 1'b0};
                o_sda_oe <= ~rd_word[7];
                bitcnt   <= 4'h1;
                state    <= S_RD;
              end else begin
                state <= S_IDLE;
              end
            end
          end
          default: begin
            state    <= S_IDLE;
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end
  // switch-node blanking after enable
  reg [15:0] blank_cnt;
  reg        node_armed;
  always @(posedge i_clk_sys) begin
    if (i_rst || !en_s) begin
      blank_cnt  <= 16'h0000;
      node_armed <= 1'b0;
    end else begin
      if (blank_cnt != P_NODE_BLANK_CYC)
        blank_cnt <= blank_cnt + 16'h0001;
      node_armed <= (blank_cnt == P_NODE_BLANK_CYC);
    end
  end

  wire fault_set = prot_en & node_armed & (node_lo_s | node_hi_s);
  wire fault_clr = wr_stb & (wr_addr == `LDR_REG_PROTECT) & wr_data[`LDR_PROT_CLR_BIT];

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      current_code <= `LDR_CURRENT_RST;
      dim_duty     <= `LDR_DIM_RST;
      prot_en      <= `LDR_PROT_EN_RST;
      guard_dis    <= `LDR_GUARD_DIS_RST;
      guard_latch  <= `LDR_GUARD_LATCH_RST;
      fault_flag   <= 1'b0;
    end else begin
      if (wr_stb && wr_addr == `LDR_REG_CURRENT)
        current_code <= wr_data;
      if (wr_stb && wr_addr == `LDR_REG_DIM)
        dim_duty <= wr_data;
      if (wr_stb && wr_addr == `LDR_REG_PROTECT) begin
        prot_en   <= wr_data[`LDR_PROT_EN_BIT];
        guard_dis   <= wr_data[`LDR_GUARD_DIS_BIT];
        guard_latch <= wr_data[`LDR_GUARD_LATCH_BIT];
      end
      fault_flag <= fault_set | (fault_flag & ~fault_clr);
    end
  end

  assign o_fault = fault_flag;

  always @(posedge i_clk_sys) begin
    if (i_rst)
      o_current_code <= `LDR_CODE_ZERO;
    else if (current_code == `LDR_CODE_ZERO)
      o_current_code <= `LDR_CODE_ZERO;
    else if (current_code < `LDR_CODE_MIN)
      o_current_code <= `LDR_CODE_MIN;
    else
      o_current_code <= current_code;
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_chan
      reg        ch_on;
      reg [11:0] retry_cnt;
      always @(posedge i_clk_sys) begin
        if (i_rst || guard_dis) begin
          ch_on     <= 1'b1;
          retry_cnt <= 12'h000;
        end else if (ch_on && over_s[g]) begin
          ch_on     <= 1'b0;
          retry_cnt <= RETRY;
        end else if (!ch_on && !guard_latch) begin
          if (retry_cnt == 12'h000)
            ch_on <= 1'b1;
          else
            retry_cnt <= retry_cnt - 12'h001;
        end
      end
      assign o_channel_on[g] = ch_on;
    end
  endgenerate

  // dimming source and mode
  wire use_reg = i_dim_src_reg && (i_dim_mode == `LDR_MODE_DC || i_dim_mode == `LDR_MODE_MIXED);
  wire pwm_reg;
  ldr_dim_pwm ldr_dim_pwm_i (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_duty    (dim_duty),
    .o_pwm     (pwm_reg)
  );

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_dim_level <= `LDR_DIM_FULL;
      o_dim_pwm   <= 1'b0;
    end else if (!use_reg) begin
      o_dim_level <= `LDR_DIM_FULL;
      o_dim_pwm   <= pin_s;
    end else if (i_dim_mode == `LDR_MODE_MIXED && dim_duty < `LDR_MIX_THRESH) begin
      // low duty chops at fixed rate
      o_dim_level <= `LDR_DIM_FULL;
      o_dim_pwm   <= pwm_reg;
    end else begin
      o_dim_level <= dim_duty;
      o_dim_pwm   <= 1'b1;
    end
  end
endmodule // ldr_smbus_regs

/* sim/ldr_smbus_regs_monitor.sv */
`timescale 1ns/1ps
module ldr_smbus_regs_monitor (
  input logic       i_clk_sys,
  input logic       i_rst,
  input logic       i_enable,
  input logic       i_switch_node_low,
  input logic       i_switch_node_high,
  input logic [3:0] i_channel_sink_pin_over,
  input logic       i_dim_pin,
  input logic       i_dim_src_reg,
  input logic [1:0] i_dim_mode,
  input logic       o_sda_oe,
  input logic       o_fault,
  input logic [3:0] o_channel_on,
  input logic [7:0] o_current_code,
  input logic [7:0] o_dim_level,
  input logic       o_dim_pwm
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // over-voltage history spans the input synchroniser delay
  logic [3:0] ovh;
  always_ff @(posedge i_clk_sys) ovh <= {ovh[2:0], i_channel_sink_pin_over[0]};
  property p_rst_out;
    $fell(i_rst) |-> !o_sda_oe && !o_fault && o_channel_on == 4'hf && o_current_code == 8'h00;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");
  property p_code_floor;
    o_current_code == 8'h00 || o_current_code >= 8'h20;
  endproperty
  a_code_floor: assert property (p_code_floor) else $error("code below floor");
  property p_no_arm;
    (!i_enable) [*8] |-> !$rose(o_fault);
  endproperty
  a_no_arm: assert property (p_no_arm) else $error("fault while disabled");
  property p_cause;
    (!i_switch_node_low && !i_switch_node_high) [*6] |-> !$rose(o_fault);
  endproperty
  a_cause: assert property (p_cause) else $error("fault without cause");
  property p_ch_off;
    $fell(o_channel_on[0]) |-> |ovh;
  endproperty
  a_ch_off: assert property (p_ch_off) else $error("channel off without over");
  property p_dc;
    (i_dim_src_reg && i_dim_mode == 2'h1) [*4] |-> o_dim_pwm;
  endproperty
  a_dc: assert property (p_dc) else $error("dc gate low");
  property p_pin;
    (!i_dim_src_reg && i_dim_pin) [*4] |-> o_dim_pwm && o_dim_level == 8'hff;
  endproperty
  a_pin: assert property (p_pin) else $error("pin dimming not followed");
  property p_oe_hold;
    $rose(o_sda_oe) |=> o_sda_oe [*3];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("sda pull too short");
  c_fault: cover property ($rose(o_fault));
  c_ch: cover property ($fell(o_channel_on[0]));
  c_ack: cover property ($rose(o_sda_oe));
endmodule // ldr_smbus_regs_monitor
bind ldr_smbus_regs ldr_smbus_regs_monitor ldr_smbus_regs_monitor_i (.*);

/* sim/ldr_host_model.sv */
`timescale 1ns/1ps
module ldr_host_model (
  input  logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  logic [7:0] dat [0:7];
  logic       ack_ok;
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  // 200 ns bit, sda moves only while scl is low
  task automatic bit_io(input logic b, output logic r);
    #25 o_sda_oe = ~b;
    #75 o_scl = 1'b1;
    #50 r = i_sda;
    #50 o_scl = 1'b0;
  endtask
  // odd first delay keeps bus edges off the system clock edges
  task automatic start_c;
    #32 o_sda_oe = 1'b0;
    #75 o_scl = 1'b1;
    #50 o_sda_oe = 1'b1;
    #50 o_scl = 1'b0;
  endtask
  task automatic stop_c;
    #25 o_sda_oe = 1'b1;
    #75 o_scl = 1'b1;
    #50 o_sda_oe = 1'b0;
    #50;
  endtask
  task automatic put_byte(input logic [7:0] d);
    logic r;
    for (int k = 7; k >= 0; k--) bit_io(d[k], r);
    bit_io(1'b1, r);
    ack_ok = ack_ok & ~r;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input int n);
    ack_ok = 1'b1;
    start_c();
    put_byte({a, 1'b0});
    put_byte(c);
    for (int i = 0; i < n; i++) put_byte(dat[i]);
    stop_c();
  endtask
  task automatic rd(input logic [7:0] c, input int n);
    logic r;
    ack_ok = 1'b1;
    start_c();
    put_byte({7'h31, 1'b0});
    put_byte(c);
    start_c();
    put_byte({7'h31, 1'b1});
    for (int i = 0; i < n; i++) begin
      for (int k = 7; k >= 0; k--) bit_io(1'b1, dat[i][k]);
      bit_io(i == n - 1, r);
    end
    stop_c();
  endtask
endmodule // ldr_host_model

/* sim/ldr_smbus_regs_test.sv */
`timescale 1ns/1ps
`include "ldr_defs.vh"
module ldr_smbus_regs_test;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       en = 1'b0;
  logic       sn_lo = 1'b0;
  logic       sn_hi = 1'b0;
  logic [3:0] ov = 4'h0;
  logic       dpin = 1'b0;
  logic       dsrc = 1'b0;
  logic [1:0] dmode = 2'h1;
  logic       scl, hoe, oe, sdo, fault, dpwm;
  logic [3:0] chon;
  logic [7:0] code, dlev, r;
  logic [15:0] cnt;
  int         fails = 0;
  int         n_tests = 0;
  // pull-up: line high unless someone pulls it
  wire        sda = ~((oe & ~sdo) | hoe);
  always #12.5 clk = ~clk;
  ldr_smbus_regs #(.P_NODE_BLANK_CYC(16'h0032)) ldr_smbus_regs_i (
    .i_clk_sys(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda_out(sdo), .o_sda_oe(oe),
    .i_enable(en), .i_switch_node_low(sn_lo), .i_switch_node_high(sn_hi), .i_channel_sink_pin_over(ov),
    .i_dim_pin(dpin), .i_dim_src_reg(dsrc), .i_dim_mode(dmode), .o_fault(fault), .o_channel_on(chon),
    .o_current_code(code), .o_dim_level(dlev), .o_dim_pwm(dpwm));
  ldr_host_model ldr_host_model_i (.i_sda(sda), .o_scl(scl), .o_sda_oe(hoe));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr1(input logic [7:0] a, input logic [7:0] d);
    ldr_host_model_i.dat[0] = d;
    ldr_host_model_i.wr(7'h31, a, 1);
  endtask
  task automatic rd1(input logic [7:0] a, output logic [7:0] d);
    ldr_host_model_i.rd(a, 1);
    d = ldr_host_model_i.dat[0];
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    // look at outputs half a cycle after the edge that launched them
    @(negedge clk);
  endtask
  task automatic t_reset_vals;
    logic [7:0] e [0:4];
    e = '{8'h00, 8'h80, 8'h00, 8'h00, {1'b1, `LDR_MAKER_ID, 4'h0}};
    ldr_host_model_i.rd(8'h02, 5);
    for (int i = 0; i < 5; i++) chk(ldr_host_model_i.dat[i], e[i]);
    chk({7'h0, ldr_host_model_i.ack_ok}, 8'h01);
  endtask
  task automatic t_codes;
    logic [7:0] c [0:5];
    c = '{8'h00, 8'h01, 8'h1f, 8'h20, 8'h21, 8'hff};
    foreach (c[i]) begin
      wr1(8'h02, c[i]);
      chk(code, c[i] == 8'h00 ? 8'h00 : (c[i] < 8'h20 ? 8'h20 : c[i]));
      rd1(8'h06, r);
      chk({7'h0, r[7]}, {7'h0, c[i] == 8'h00});
    end
    ldr_host_model_i.dat[0] = 8'h40;
    ldr_host_model_i.dat[1] = 8'h80;
    ldr_host_model_i.dat[2] = 8'h7f;
    ldr_host_model_i.wr(7'h31, 8'h02, 3);
    chk({7'h0, ldr_host_model_i.ack_ok}, 8'h01);
    ldr_host_model_i.rd(8'h02, 3);
    chk(ldr_host_model_i.dat[2], 8'h7f);
    ldr_host_model_i.dat[0] = 8'h11;
    ldr_host_model_i.wr(7'h30, 8'h02, 1);
    chk({7'h0, ldr_host_model_i.ack_ok}, 8'h00);
    chk(code, 8'h40);
  endtask
  task automatic t_fault;
    @(posedge clk);
    en <= 1'b1;
    sn_lo <= 1'b1;
    cyc(40);
    chk({7'h0, fault}, 8'h00);
    cyc(30);
    chk({7'h0, fault}, 8'h01);
    @(posedge clk);
    sn_lo <= 1'b0;
    wr1(8'h03, 8'h80);
    rd1(8'h03, r);
    chk(r, 8'h81);
    // fault gone, so the host may now clear the flag
    wr1(8'h03, 8'h88);
    rd1(8'h03, r);
    chk(r, 8'h80);
    wr1(8'h03, 8'h00);
    @(posedge clk);
    sn_hi <= 1'b1;
    cyc(10);
    chk({7'h0, fault}, 8'h00);
    @(posedge clk);
    sn_hi <= 1'b0;
    en <= 1'b0;
  endtask
  task automatic t_short_guard;
    @(posedge clk);
    ov <= 4'h1;
    cyc(8);
    chk({4'h0, chon}, 8'h0e);
    @(posedge clk);
    ov <= 4'h0;
    cyc(4100);
    chk({4'h0, chon}, 8'h0f);
    wr1(8'h03, 8'h02);
    @(posedge clk);
    ov <= 4'h2;
    cyc(8);
    @(posedge clk);
    ov <= 4'h0;
    cyc(4100);
    chk({4'h0, chon}, 8'h0d);
    wr1(8'h03, 8'h04);
    @(posedge clk);
    ov <= 4'h4;
    cyc(8);
    chk({4'h0, chon}, 8'h0f);
    @(posedge clk);
    ov <= 4'h0;
  endtask
  task automatic t_dim;
    @(posedge clk);
    dsrc <= 1'b1;
    cyc(8);
    chk(dlev, 8'h7f);
    chk({7'h0, dpwm}, 8'h01);
    @(posedge clk);
    dmode <= `LDR_MODE_PWM;
    cyc(8);
    chk({7'h0, dpwm}, 8'h00);
    @(posedge clk);
    dsrc <= 1'b0;
    dpin <= 1'b1;
    cyc(8);
    chk({7'h0, dpwm}, 8'h01);
    wr1(8'h04, 8'h10);
    @(posedge clk);
    dsrc <= 1'b1;
    dmode <= `LDR_MODE_MIXED;
    cyc(8);
    cnt = 16'h0000;
    repeat (`LDR_DIM_PERIOD_CYC) begin
      @(negedge clk);
      cnt = cnt + {15'h0000, dpwm};
    end
    chk(cnt[7:0], 8'(8'h10 * `LDR_DIM_STEP_CYC));
    chk(cnt[15:8], 8'h00);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cyc(4);
    t_reset_vals();
    t_codes();
    t_fault();
    t_short_guard();
    t_dim();
    end_of_test();
  end
  initial begin
    #2000000;
    fails++;
    end_of_test();
  end
endmodule // ldr_smbus_regs_test
